// [design/dsq_map.vh]
// Offsets, field positions, reset values and counts of the sequencer block
`ifndef DSQ_MAP_VH
`define DSQ_MAP_VH

// Byte-port register offsets
`define DSQ_OFS_CTRL      8'h00
`define DSQ_OFS_PC        8'h01
`define DSQ_OFS_TRG       8'h02
`define DSQ_OFS_CLR       8'h03
`define DSQ_OFS_DBG       8'h04
`define DSQ_OFS_SGL_BASE  8'h08
`define DSQ_SGL_SPAN      8'h0e
`define DSQ_OFS_PAIR_BASE 8'h20
`define DSQ_PAIR_SPAN     8'h1c
`define DSQ_OFS_PM_DATL   8'h40
`define DSQ_OFS_PM_DATH   8'h41
`define DSQ_OFS_PM_ADR    8'h42

// Control register fields
`define DSQ_CTRL_EN       0
`define DSQ_CTRL_IE       1
`define DSQ_CTRL_IF       2
`define DSQ_CTRL_SA       3
`define DSQ_CTRL_SS       4
`define DSQ_CTRL_RST      8'h00

// Debug and counter-clear fields
`define DSQ_DBG_MODE      0
`define DSQ_DBG_STEP      1
`define DSQ_CLR_CPU       0
`define DSQ_CLR_XFER      1
`define DSQ_CLR_EV        2

// Instruction fields
`define DSQ_INS_WAIT      15
`define DSQ_INS_SEL_HI    14
`define DSQ_INS_SEL_LO    12
`define DSQ_INS_EVT       11
`define DSQ_SEL_EVB       3'h7

// Program counter and memory
`define DSQ_PC_FIRST      6'h00
`define DSQ_PC_LAST       6'h2f
`define DSQ_PM_DEPTH      48
`define DSQ_PM_LIMIT      6'h30

// Wide register file
`define DSQ_NREG          14
`define DSQ_NTRIG         8
`define DSQ_SFR_LIMIT     4'he

// Bus masters on the byte port
`define DSQ_MST_CPU       2'h0
`define DSQ_MST_XFER      2'h1
`define DSQ_MST_EV        2'h2

`endif

// [design/dsq_seq_access.v]
// Sequencer, trigger wait and byte-wise wide register access
//
// Design decisions made here: the register offsets and the plain strobed port.
`timescale 1ns/100ps
`include "dsq_map.vh"

// Functional notes
// - Setting enable starts the sequence at the preloadable program counter.
// - Wait-flagged instruction holds until its selected R0..R7 is written.
// - On trigger, execute the held instruction then advance the counter.
// - External write to R0..R7 sets its trigger bit; resuming clears it.
// - Trigger bit already set: execute at once, then clear the bit.
// - Counter at 0x2F wraps to 0x00 and the sequence continues.
// - Event-flagged completion sets the interrupt flag and pulses events.
// - Interrupt output is flag AND interrupt enable.
// - ALU and shifter saturation set sticky flags cleared by the CPU.
// - In debug mode each write of 1 to step runs one instruction.
// - Setting debug mode and step in one write runs no step.
// - Debug steps ignore the wait flag; counter wrap still applies.
// - External master wins over the coprocessor on the same register.
// - Wide writes: low byte held, both bytes committed with the high byte.
// - Wide reads: low byte returned, high byte captured for next read.
// - Wide registers decode at one single and two paired addresses.
// - XDATA write beats a simultaneous SFR access to a limit register.
// - CPU has separate SFR and XDATA read counters, one clear bit.
// - Transfer and event unit read counters each have own clear bit.
// - Select 7 pulses event line B, other selects event line A.
// - Program memory: 48 words, address written first, then data bytes.
// - Program memory byte writes land immediately; reads follow address.
// - Select field in bits 14..12 is binary register number.
module dsq_seq_access (
    input  wire        SYS_CLK_IN,      // System clock, 10 MHz
    input  wire        RST_IN,          // Synchronous reset, active high
    input  wire        CLK_EN_IN,       // Clock enable, freezes state low
    input  wire [1:0]  REG_MST_IN,      // Byte-port master id
    input  wire [7:0]  REG_ADDR_IN,     // Byte-port address
    input  wire [7:0]  REG_WDATA_IN,    // Byte-port write data
    input  wire        REG_WR_IN,       // Byte-port write strobe
    input  wire        REG_RD_IN,       // Byte-port read strobe
    output reg  [7:0]  REG_RDATA_OUT,   // Byte-port read data
    input  wire [3:0]  SFR_ADDR_IN,     // SFR register index
    input  wire [15:0] SFR_WDATA_IN,    // SFR write data
    input  wire        SFR_WIDE_IN,     // SFR 16-bit transfer
    input  wire        SFR_WR_IN,       // SFR write strobe
    input  wire        SFR_RD_IN,       // SFR read strobe
    output reg  [15:0] SFR_RDATA_OUT,   // SFR read data
    input  wire        COP_WR_IN,       // Datapath register write
    input  wire [3:0]  COP_SEL_IN,      // Datapath write index
    input  wire [15:0] COP_WDATA_IN,    // Datapath write data
    output wire        COP_WR_LOST_OUT, // Datapath write overridden
    input  wire [3:0]  COP_RSEL_IN,     // Datapath read index
    output reg  [15:0] COP_RDATA_OUT,   // Datapath read data
    output reg         EXEC_START_OUT,  // Instruction issue pulse
    output reg  [15:0] INSTR_OUT,       // Instruction being executed
    output reg  [5:0]  PC_OUT,          // Program counter
    input  wire        EXEC_DONE_IN,    // Datapath completion pulse
    input  wire        SAT_ALU_IN,      // ALU saturated
    input  wire        SAT_SHF_IN,      // Shifter saturated
    output reg         EVENT_A_OUT,     // Event line A pulse
    output reg         EVENT_B_OUT,     // Event line B pulse
    output wire        IRQ_OUT          // Interrupt request
);

    localparam [3:0] ST_IDLE  = 4'b0001;
    localparam [3:0] ST_FETCH = 4'b0010;
    localparam [3:0] ST_WAIT  = 4'b0100;
    localparam [3:0] ST_EXEC  = 4'b1000;

    reg  [15:0] wreg_q [0:`DSQ_NREG-1];
    reg  [15:0] pmem_q [0:`DSQ_PM_DEPTH-1];
    reg  [3:0]  state_q;
    reg         en_q;
    reg         ie_q;
    reg         if_q;
    reg         sa_q;
    reg         ss_q;
    reg         dbg_q;
    reg         step_q;
    reg         forced_q;
    reg  [7:0]  trg_q;
    reg  [5:0]  pm_adr_q;
    reg  [3:0]  rcnt_q;
    reg  [7:0]  rhold_q [0:3];
    reg         xwph_q;
    reg  [7:0]  xwhold_q;
    reg         swph_q;
    reg  [7:0]  swhold_q;

    wire [7:0]  x_sgl_off  = REG_ADDR_IN - `DSQ_OFS_SGL_BASE;
    wire [7:0]  x_pair_off = REG_ADDR_IN - `DSQ_OFS_PAIR_BASE;
    wire        x_sgl_hit  = x_sgl_off < `DSQ_SGL_SPAN;
    wire        x_pair_hit = x_pair_off < `DSQ_PAIR_SPAN;
    wire        x_wide_hit = x_sgl_hit | x_pair_hit;
    wire [3:0]  x_idx      = x_sgl_hit ? x_sgl_off[3:0] : x_pair_off[4:1];
    wire [1:0]  rci        = (REG_MST_IN == 2'h3) ? `DSQ_MST_CPU : REG_MST_IN;
    wire        s_hit      = SFR_ADDR_IN < `DSQ_SFR_LIMIT;
    wire        pm_ok      = pm_adr_q < `DSQ_PM_LIMIT;
    wire [15:0] x_word     = wreg_q[x_idx];
    wire [15:0] s_word     = wreg_q[SFR_ADDR_IN];
    wire [15:0] pm_word    = pm_ok ? pmem_q[pm_adr_q] : 16'h0000;

    // Pair address picks the byte; single address follows the counter
    wire x_rd_hi = x_pair_hit ? x_pair_off[0] : rcnt_q[rci];
    wire x_wr_hi = x_pair_hit ? x_pair_off[0] : xwph_q;

    wire        xw_go  = REG_WR_IN & x_wide_hit & x_wr_hi;
    wire [15:0] xw_val = {REG_WDATA_IN, xwhold_q};
    wire        sw_go  = SFR_WR_IN & s_hit & (SFR_WIDE_IN | swph_q);
    wire [15:0] sw_val = SFR_WIDE_IN ? SFR_WDATA_IN
                                     : {SFR_WDATA_IN[7:0], swhold_q};

    wire wr_ctrl = REG_WR_IN & (REG_ADDR_IN == `DSQ_OFS_CTRL);
    wire wr_pc   = REG_WR_IN & (REG_ADDR_IN == `DSQ_OFS_PC);
    wire wr_trg  = REG_WR_IN & (REG_ADDR_IN == `DSQ_OFS_TRG);
    wire wr_clr  = REG_WR_IN & (REG_ADDR_IN == `DSQ_OFS_CLR);
    wire wr_dbg  = REG_WR_IN & (REG_ADDR_IN == `DSQ_OFS_DBG);
    wire wr_datl = REG_WR_IN & (REG_ADDR_IN == `DSQ_OFS_PM_DATL);
    wire wr_dath = REG_WR_IN & (REG_ADDR_IN == `DSQ_OFS_PM_DATH);
    wire wr_adr  = REG_WR_IN & (REG_ADDR_IN == `DSQ_OFS_PM_ADR);

    wire [2:0] sel    = INSTR_OUT[`DSQ_INS_SEL_HI:`DSQ_INS_SEL_LO];
    wire       waitf  = INSTR_OUT[`DSQ_INS_WAIT];
    wire       in_wait = (state_q == ST_WAIT) & en_q;
    wire       go_free = in_wait & (forced_q | ~waitf);
    wire       go_trig = in_wait & ~forced_q & waitf & trg_q[sel];
    wire       done   = (state_q == ST_EXEC) & EXEC_DONE_IN;
    wire       evt    = done & INSTR_OUT[`DSQ_INS_EVT];
    wire [7:0] consume = go_trig ? (8'h01 << sel) : 8'h00;
    wire [`DSQ_NTRIG-1:0] trg_set;

    assign IRQ_OUT = if_q & ie_q;

    // Byte-port writes lose to nobody; SFR writes yield to them; the datapath yields to both buses
    assign COP_WR_LOST_OUT = COP_WR_IN &
                             ((xw_go & (x_idx == COP_SEL_IN)) |
                              (sw_go & (SFR_ADDR_IN == COP_SEL_IN)));

    genvar gi;
    generate
        for (gi = 0; gi < `DSQ_NREG; gi = gi + 1) begin : g_reg
            wire x_this = xw_go & (x_idx == gi);
            wire s_this = sw_go & (SFR_ADDR_IN == gi);
            wire c_this = COP_WR_IN & (COP_SEL_IN == gi);
            always @(posedge SYS_CLK_IN) begin
                if (RST_IN) begin
                    wreg_q[gi] <= 16'h0000;
                end else if (CLK_EN_IN) begin
                    if (x_this) begin
                        wreg_q[gi] <= xw_val;
                    end else if (s_this) begin
                        wreg_q[gi] <= sw_val;
                    end else if (c_this) begin
                        wreg_q[gi] <= COP_WDATA_IN;
                    end
                end
            end
            if (gi < `DSQ_NTRIG) begin : g_trg
                assign trg_set[gi] = x_this | s_this;
            end
        end
    endgenerate

    // Program memory carries no reset; software loads it before enabling
    always @(posedge SYS_CLK_IN) begin
        if (CLK_EN_IN && pm_ok) begin
            if (wr_datl) begin
                pmem_q[pm_adr_q] <= {pmem_q[pm_adr_q][15:8],
                                     REG_WDATA_IN};
            end else if (wr_dath) begin
                pmem_q[pm_adr_q] <= {REG_WDATA_IN,
                                     pmem_q[pm_adr_q][7:0]};
            end
        end
    end

    // Control, flags, trigger status and debug controls
    always @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            en_q     <= 1'b0;
            ie_q     <= 1'b0;
            if_q     <= 1'b0;
            sa_q     <= 1'b0;
            ss_q     <= 1'b0;
            dbg_q    <= 1'b0;
            step_q   <= 1'b0;
            trg_q    <= 8'h00;
            pm_adr_q <= 6'h00;
        end else if (CLK_EN_IN) begin
            if (wr_ctrl) begin
                en_q <= REG_WDATA_IN[`DSQ_CTRL_EN];
                ie_q <= REG_WDATA_IN[`DSQ_CTRL_IE];
            end
            // Hardware set wins over a software clear in the same cycle
            if_q <= (wr_ctrl ? REG_WDATA_IN[`DSQ_CTRL_IF] : if_q)
                    | evt;
            sa_q <= (wr_ctrl ? REG_WDATA_IN[`DSQ_CTRL_SA] : sa_q)
                    | ((state_q == ST_EXEC) & SAT_ALU_IN);
            ss_q <= (wr_ctrl ? REG_WDATA_IN[`DSQ_CTRL_SS] : ss_q)
                    | ((state_q == ST_EXEC) & SAT_SHF_IN);
            trg_q <= (((wr_trg ? REG_WDATA_IN : trg_q) & ~consume)
                     | trg_set);
            if (wr_dbg) begin
                dbg_q <= REG_WDATA_IN[`DSQ_DBG_MODE];
            end
            // Step counts only if debug mode was already on
            if (wr_dbg && dbg_q && REG_WDATA_IN[`DSQ_DBG_MODE] &&
                REG_WDATA_IN[`DSQ_DBG_STEP]) begin
                step_q <= 1'b1;
            end else if (wr_dbg && !REG_WDATA_IN[`DSQ_DBG_MODE]) begin
                step_q <= 1'b0;
            end else if (state_q == ST_IDLE && en_q && dbg_q) begin
                step_q <= 1'b0;
            end
            if (wr_adr) begin
                pm_adr_q <= REG_WDATA_IN[5:0];
            end
        end
    end

    // Sequencer
    always @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            state_q        <= ST_IDLE;
            PC_OUT         <= `DSQ_PC_FIRST;
            INSTR_OUT      <= 16'h0000;
            forced_q       <= 1'b0;
            EXEC_START_OUT <= 1'b0;
            EVENT_A_OUT    <= 1'b0;
            EVENT_B_OUT    <= 1'b0;
        end else if (CLK_EN_IN) begin
            EXEC_START_OUT <= 1'b0;
            EVENT_A_OUT    <= evt & (sel != `DSQ_SEL_EVB);
            EVENT_B_OUT    <= evt & (sel == `DSQ_SEL_EVB);
            case (state_q)
                ST_IDLE: begin
                    if (wr_pc && !en_q) begin
                        PC_OUT <= REG_WDATA_IN[5:0];
                    end
                    if (en_q && (!dbg_q || step_q)) begin
                        forced_q <= dbg_q;
                        state_q  <= ST_FETCH;
                    end
                end
                ST_FETCH: begin
                    if (!en_q) begin
                        state_q <= ST_IDLE;
                    end else begin
                        INSTR_OUT <= pmem_q[PC_OUT];
                        state_q   <= ST_WAIT;
                    end
                end
                ST_WAIT: begin
                    if (!en_q) begin
                        state_q <= ST_IDLE;
                    end else if (go_free || go_trig) begin
                        EXEC_START_OUT <= 1'b1;
                        state_q        <= ST_EXEC;
                    end
                end
                ST_EXEC: begin
                    // An issued instruction always finishes, even if disabled
                    if (EXEC_DONE_IN) begin
                        if (PC_OUT == `DSQ_PC_LAST) begin
                            PC_OUT <= `DSQ_PC_FIRST;
                        end else begin
                            PC_OUT <= PC_OUT + 6'h01;
                        end
                        state_q <= ST_IDLE;
                    end
                end
                default: begin
                    state_q <= ST_IDLE;
                end
            endcase
        end
    end

    // Byte-order counters, capture and write holding registers
    always @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            rcnt_q     <= 4'h0;
            rhold_q[0] <= 8'h00;
            rhold_q[1] <= 8'h00;
            rhold_q[2] <= 8'h00;
            rhold_q[3] <= 8'h00;
            xwph_q     <= 1'b0;
            xwhold_q   <= 8'h00;
            swph_q     <= 1'b0;
            swhold_q   <= 8'h00;
        end else if (CLK_EN_IN) begin
            if (REG_RD_IN && x_wide_hit) begin
                if (!x_rd_hi) begin
                    rhold_q[rci] <= x_word[15:8];
                    rcnt_q[rci]  <= 1'b1;
                end else begin
                    rcnt_q[rci]  <= 1'b0;
                end
            end
            if (SFR_RD_IN && s_hit && !SFR_WIDE_IN) begin
                if (!rcnt_q[3]) begin
                    rhold_q[3] <= s_word[15:8];
                    rcnt_q[3]  <= 1'b1;
                end else begin
                    rcnt_q[3]  <= 1'b0;
                end
            end
            if (wr_clr) begin
                if (REG_WDATA_IN[`DSQ_CLR_CPU]) begin
                    rcnt_q[0] <= 1'b0;
                    rcnt_q[3] <= 1'b0;
                end
                if (REG_WDATA_IN[`DSQ_CLR_XFER]) begin
                    rcnt_q[1] <= 1'b0;
                end
                if (REG_WDATA_IN[`DSQ_CLR_EV]) begin
                    rcnt_q[2] <= 1'b0;
                end
            end
            if (REG_WR_IN && x_wide_hit) begin
                if (!x_wr_hi) begin
                    xwhold_q <= REG_WDATA_IN;
                    xwph_q   <= 1'b1;
                end else begin
                    xwph_q   <= 1'b0;
                end
            end
            // Full-width transfers bypass the holding path
            if (SFR_WR_IN && s_hit && !SFR_WIDE_IN) begin
                if (!swph_q) begin
                    swhold_q <= SFR_WDATA_IN[7:0];
                    swph_q   <= 1'b1;
                end else begin
                    swph_q   <= 1'b0;
                end
            end
        end
    end

    // Read data, one cycle after the strobe; unmapped reads return zero
    always @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            REG_RDATA_OUT <= 8'h00;
            SFR_RDATA_OUT <= 16'h0000;
            COP_RDATA_OUT <= 16'h0000;
        end else if (CLK_EN_IN) begin
            COP_RDATA_OUT <= (COP_RSEL_IN < `DSQ_SFR_LIMIT) ?
                             wreg_q[COP_RSEL_IN] : 16'h0000;
            REG_RDATA_OUT <= 8'h00;
            if (REG_RD_IN) begin
                if (x_wide_hit) begin
                    REG_RDATA_OUT <= x_rd_hi ? rhold_q[rci]
                                             : x_word[7:0];
                end else begin
                    case (REG_ADDR_IN)
                        `DSQ_OFS_CTRL:
                            REG_RDATA_OUT <= {3'h0, ss_q, sa_q, if_q,
                                              ie_q, en_q};
                        `DSQ_OFS_PC:
                            REG_RDATA_OUT <= {2'h0, PC_OUT};
                        `DSQ_OFS_TRG:
                            REG_RDATA_OUT <= trg_q;
                        `DSQ_OFS_DBG:
                            REG_RDATA_OUT <= {7'h00, dbg_q};
                        `DSQ_OFS_PM_DATL:
                            REG_RDATA_OUT <= pm_word[7:0];
                        `DSQ_OFS_PM_DATH:
                            REG_RDATA_OUT <= pm_word[15:8];
                        `DSQ_OFS_PM_ADR:
                            REG_RDATA_OUT <= {2'h0, pm_adr_q};
                        default:
                            REG_RDATA_OUT <= 8'h00;
                    endcase
                end
            end
            SFR_RDATA_OUT <= 16'h0000;
            if (SFR_RD_IN && s_hit) begin
                if (SFR_WIDE_IN) begin
                    SFR_RDATA_OUT <= s_word;
                end else if (rcnt_q[3]) begin
                    SFR_RDATA_OUT <= {8'h00, rhold_q[3]};
                end else begin
                    SFR_RDATA_OUT <= {8'h00, s_word[7:0]};
                end
            end
        end
    end

endmodule

// [dv/dsq_dp_model.sv]
// Datapath stand-in that answers issue pulses with completion
`timescale 1ns/100ps
module dsq_dp_model (
    input  wire       clk_in,   // System clock
    input  wire       rst_in,   // Synchronous reset
    input  wire       start_in, // Issue pulse
    input  wire       slow_in,  // Long latency when high
    input  wire [1:0] sat_in,   // Saturation to report
    output reg        done_out, // Completion pulse
    output wire       alu_out,  // ALU saturation
    output wire       shf_out   // Shifter saturation
);
    reg       busy_q;
    reg [2:0] cnt_q;
    // Shown only while busy, so late flags would be missed
    assign alu_out = busy_q & sat_in[0];
    assign shf_out = busy_q & sat_in[1];
    always @(posedge clk_in) begin
        if (rst_in) begin
            busy_q   <= 1'b0;
            cnt_q    <= 3'h0;
            done_out <= 1'b0;
        end else begin
            done_out <= busy_q && cnt_q == 3'h1;
            if (start_in) begin
                busy_q <= 1'b1;
                cnt_q  <= slow_in ? 3'h4 : 3'h1;
            end else if (busy_q) begin
                busy_q <= cnt_q != 3'h1;
                cnt_q  <= cnt_q - 3'h1;
            end
        end
    end
endmodule

// [dv/dsq_seq_checker.sv]
// Port assertions for the sequencer block
`timescale 1ns/100ps
module dsq_seq_checker (
    input wire        SYS_CLK_IN,     // Clock
    input wire        RST_IN,         // Reset
    input wire        REG_RD_IN,      // Byte read strobe
    input wire [7:0]  REG_RDATA_OUT,  // Byte read data
    input wire        SFR_RD_IN,      // SFR read strobe
    input wire [15:0] SFR_RDATA_OUT,  // SFR read data
    input wire        EXEC_START_OUT, // Issue pulse
    input wire        EXEC_DONE_IN,   // Completion pulse
    input wire [15:0] INSTR_OUT,      // Current instruction
    input wire [5:0]  PC_OUT,         // Program counter
    input wire        EVENT_A_OUT,    // Event line A
    input wire        EVENT_B_OUT,    // Event line B
    input wire        IRQ_OUT         // Interrupt
);
    reg busy_q;
    always @(posedge SYS_CLK_IN) begin
        if (RST_IN)
            busy_q <= 1'b0;
        else if (EXEC_START_OUT)
            busy_q <= 1'b1;
        else if (EXEC_DONE_IN)
            busy_q <= 1'b0;
    end
    default clocking cb @(posedge SYS_CLK_IN); endclocking
    default disable iff (RST_IN);
    a_reset_clear: assert property (
        $fell(RST_IN) |-> PC_OUT == 6'h00 && !IRQ_OUT && !EXEC_START_OUT)
        else $error("outputs not clear after reset");
    a_pc_advance: assert property (
        busy_q && EXEC_DONE_IN |=> PC_OUT == ($past(PC_OUT) == 6'h2f ?
        6'h00 : $past(PC_OUT) + 6'h01))
        else $error("program counter did not advance");
    a_event_b_sel: assert property (
        EVENT_B_OUT |-> $past(INSTR_OUT[14:12]) == 3'h7 &&
        $past(INSTR_OUT[11]))
        else $error("event line b without select 7");
    a_event_a_sel: assert property (
        EVENT_A_OUT |-> $past(INSTR_OUT[14:12]) != 3'h7 &&
        $past(INSTR_OUT[11]))
        else $error("event line a with wrong select");
    a_done_event: assert property (
        busy_q && EXEC_DONE_IN && INSTR_OUT[11] |=> EVENT_A_OUT || EVENT_B_OUT)
        else $error("event missing after completion");
    a_event_cause: assert property (
        EVENT_A_OUT || EVENT_B_OUT |-> $past(EXEC_DONE_IN) && $past(busy_q))
        else $error("event without completion");
    a_one_issue: assert property (
        busy_q |-> !EXEC_START_OUT)
        else $error("issue while busy");
    a_rd_idle: assert property (
        !REG_RD_IN |=> REG_RDATA_OUT == 8'h00)
        else $error("byte read data without read");
    a_sfr_idle: assert property (
        !SFR_RD_IN |=> SFR_RDATA_OUT == 16'h0000)
        else $error("sfr read data without read");
endmodule
bind dsq_seq_access dsq_seq_checker dsq_seq_checker_i (.SYS_CLK_IN,
    .RST_IN, .REG_RD_IN, .REG_RDATA_OUT, .SFR_RD_IN, .SFR_RDATA_OUT,
    .EXEC_START_OUT, .EXEC_DONE_IN, .INSTR_OUT, .PC_OUT, .EVENT_A_OUT,
    .EVENT_B_OUT, .IRQ_OUT);

// [dv/tb.sv]
// Self-checking bench for the sequencer and access block
`timescale 1ns/100ps
module tb;
    reg         clk = 1'b0, rst = 1'b1, rwr = 1'b0, rrd = 1'b0, slow = 1'b0;
    reg  [1:0]  mst = 2'h0, sat = 2'h0;
    reg  [7:0]  adr = 8'h00, wd = 8'h00;
    reg  [3:0]  sadr = 4'h0;
    reg  [15:0] swd = 16'h0000;
    reg         swide = 1'b0, swr = 1'b0, srd = 1'b0, cwr = 1'b0;
    wire [7:0]  rdat;
    wire [15:0] srdat, instr, crd;
    wire [5:0]  pc;
    wire        start, done, sala, sshf, eva, evb, irq, lost;
    integer     errors = 0, checks = 0, starts = 0, na = 0, nb = 0, cyc = 0;
    integer     i;
    initial forever #50 clk = ~clk;
    dsq_seq_access dsq_seq_access_i (.SYS_CLK_IN(clk), .RST_IN(rst),
        .CLK_EN_IN(1'b1), .REG_MST_IN(mst), .REG_ADDR_IN(adr),
        .REG_WDATA_IN(wd), .REG_WR_IN(rwr), .REG_RD_IN(rrd),
        .REG_RDATA_OUT(rdat), .SFR_ADDR_IN(sadr), .SFR_WDATA_IN(swd),
        .SFR_WIDE_IN(swide), .SFR_WR_IN(swr), .SFR_RD_IN(srd),
        .SFR_RDATA_OUT(srdat), .COP_WR_IN(cwr), .COP_SEL_IN(4'h8),
        .COP_WDATA_IN(16'h9999), .COP_WR_LOST_OUT(lost), .COP_RSEL_IN(4'h8),
        .COP_RDATA_OUT(crd), .EXEC_START_OUT(start), .INSTR_OUT(instr),
        .PC_OUT(pc), .EXEC_DONE_IN(done), .SAT_ALU_IN(sala),
        .SAT_SHF_IN(sshf), .EVENT_A_OUT(eva), .EVENT_B_OUT(evb),
        .IRQ_OUT(irq));
    dsq_dp_model dsq_dp_model_i (.clk_in(clk), .rst_in(rst),
        .start_in(start), .slow_in(slow), .sat_in(sat), .done_out(done),
        .alu_out(sala), .shf_out(sshf));
    task conclude;
        begin
            $display("checks %0d errors %0d", checks, errors);
            if (errors == 0 && checks > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    task chk(input string nm, input [15:0] e, input [15:0] g);
        begin
            checks = checks + 1;
            if (g !== e) begin
                errors = errors + 1;
                $display("mismatch %s expected %h seen %h", nm, e, g);
            end
        end
    endtask
    task bw(input [1:0] m, input [7:0] a, input [7:0] d);
        begin
            @(posedge clk);
            mst <= m;
            adr <= a;
            wd  <= d;
            rwr <= 1'b1;
            @(posedge clk);
            rwr <= 1'b0;
        end
    endtask
    task br(input [1:0] m, input [7:0] a, input [7:0] e);
        begin
            @(posedge clk);
            mst <= m;
            adr <= a;
            rrd <= 1'b1;
            @(posedge clk);
            rrd <= 1'b0;
            #1 chk("reg read", {8'h00, e}, {8'h00, rdat});
        end
    endtask
    // SFR write path: always full 16-bit transfers
    task sw(input [3:0] a, input [15:0] d);
        begin
            @(posedge clk);
            sadr  <= a;
            swd   <= d;
            swide <= 1'b1;
            swr   <= 1'b1;
            @(posedge clk);
            swr   <= 1'b0;
        end
    endtask
    task sr(input [3:0] a, input w, input [15:0] e);
        begin
            @(posedge clk);
            sadr  <= a;
            swide <= w;
            srd   <= 1'b1;
            @(posedge clk);
            srd   <= 1'b0;
            #1 chk("sfr read", e, srdat);
        end
    endtask
    task pm(input [5:0] a, input [15:0] d);
        begin
            bw(2'h0, 8'h42, {2'b00, a});
            bw(2'h0, 8'h40, d[7:0]);
            bw(2'h0, 8'h41, d[15:8]);
        end
    endtask
    task waitpc(input [5:0] p);
        integer k;
        begin
            for (k = 0; k < 300 && pc !== p; k = k + 1) begin
                @(posedge clk);
                #1;
            end
            chk("pc", {10'h000, p}, {10'h000, pc});
        end
    endtask
    always @(posedge clk) begin
        cyc = cyc + 1;
        starts = starts + (start === 1'b1);
        na = na + (eva === 1'b1);
        nb = nb + (evb === 1'b1);
        if (cyc == 20000) begin
            errors = errors + 1;
            conclude;
        end
    end
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        br(2'h0, 8'h00, 8'h00);
        br(2'h0, 8'h02, 8'h00);
        br(2'h0, 8'h04, 8'h00);
        $display("test reset done");
        bw(2'h0, 8'h26, 8'h34);
        bw(2'h0, 8'h27, 8'h12);
        br(2'h0, 8'h02, 8'h08);
        sr(4'h3, 1'b1, 16'h1234);
        for (i = 0; i < 3; i = i + 1) begin
            br(i[1:0], 8'h0b, 8'h34);
            bw(2'h0, 8'h03, 8'h01 << i);
            br(i[1:0], 8'h0b, 8'h34);
        end
        br(2'h0, 8'h0b, 8'h12);
        sr(4'h3, 1'b0, 16'h0034);
        br(2'h0, 8'h0b, 8'h34);
        sr(4'h3, 1'b0, 16'h0012);
        bw(2'h0, 8'h10, 8'hcd);
        fork
            bw(2'h0, 8'h10, 8'hab);
            sw(4'h8, 16'h5555);
            begin
                @(posedge clk);
                cwr <= 1'b1;
                #1 chk("lost", 16'd1, {15'h0000, lost});
                @(posedge clk);
                cwr <= 1'b0;
            end
        join
        sr(4'h8, 1'b1, 16'habcd);
        chk("cop read", 16'habcd, crd);
        $display("test access done");
        pm(6'h2e, 16'h7800);
        pm(6'h2f, 16'hb800);
        pm(6'h00, 16'hd000);
        pm(6'h01, 16'hd000);
        bw(2'h0, 8'h42, 8'h2f);
        br(2'h0, 8'h40, 8'h00);
        br(2'h0, 8'h41, 8'hb8);
        bw(2'h0, 8'h01, 8'h2e);
        bw(2'h0, 8'h00, 8'h03);
        waitpc(6'h00);
        repeat (20) @(posedge clk);
        chk("starts", 16'd2, starts[15:0]);
        chk("event b", 16'd1, nb[15:0]);
        chk("event a", 16'd1, na[15:0]);
        chk("irq", 16'd1, {15'h0000, irq});
        br(2'h0, 8'h02, 8'h00);
        sat <= 2'b11;
        slow <= 1'b1;
        sw(4'h5, 16'h0055);
        waitpc(6'h01);
        chk("starts", 16'd3, starts[15:0]);
        br(2'h0, 8'h00, 8'h1f);
        bw(2'h0, 8'h00, 8'h05);
        #1 chk("irq", 16'd0, {15'h0000, irq});
        br(2'h0, 8'h00, 8'h05);
        sat <= 2'b00;
        $display("test sequence done");
        bw(2'h0, 8'h00, 8'h00);
        bw(2'h0, 8'h01, 8'h2f);
        bw(2'h0, 8'h04, 8'h03);
        bw(2'h0, 8'h00, 8'h01);
        repeat (20) @(posedge clk);
        chk("starts", 16'd3, starts[15:0]);
        bw(2'h0, 8'h04, 8'h03);
        waitpc(6'h00);
        repeat (20) @(posedge clk);
        chk("starts", 16'd4, starts[15:0]);
        chk("event a", 16'd2, na[15:0]);
        $display("test debug done");
        conclude;
    end
endmodule
